// *** cbtfm_pkg.sv ***
// constants, register map and types for the CAN bit timing and filter mask block
// assumes a 100 MHz REF_CLK and a 32-bit APB register port
package cbtfm_pkg;

    // apb geometry
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam int          REG_W           = 16;

    // register byte offsets
    localparam logic [11:0] TIMING_OFFSET   = 12'h000;
    localparam logic [11:0] BUFPTR_OFFSET   = 12'h004;
    localparam logic [11:0] MASK_SID_OFFSET = 12'h008;
    localparam logic [11:0] MASK_EID_OFFSET = 12'h00C;
    localparam logic [11:0] STATUS_OFFSET   = 12'h010;

    // writable bits per register, the rest read as zero
    localparam logic [15:0] TIMING_WMASK    = 16'h47FF;
    localparam logic [15:0] BUFPTR_WMASK    = 16'hFFFF;
    localparam logic [15:0] MASK_SID_WMASK  = 16'hFFEB;
    localparam logic [15:0] MASK_EID_WMASK  = 16'hFFFF;

    // reset values
    localparam logic [15:0] TIMING_RESET    = 16'h0000;
    localparam logic [15:0] BUFPTR_RESET    = 16'h0000;
    localparam logic [15:0] MASK_SID_RESET  = 16'h0000;
    localparam logic [15:0] MASK_EID_RESET  = 16'h0000;

    // timing register fields
    localparam int          PROP_LSB        = 0;
    localparam int          PH1_LSB         = 3;
    localparam int          TRIPLE_BIT      = 6;
    localparam int          PH2_SEL_BIT     = 7;
    localparam int          PH2_LSB         = 8;
    localparam int          WAKE_FILT_BIT   = 14;
    localparam int          SEG_FIELD_W     = 3;

    // mask register fields
    localparam int          SID_MASK_LSB    = 5;
    localparam int          SID_W           = 11;
    localparam int          TYPE_MODE_BIT   = 3;
    localparam int          EID_HI_W        = 2;
    localparam int          EID_W           = 18;
    localparam int          ID_W            = 29;

    // buffer pointer fields
    localparam int          PTR_W           = 4;
    localparam logic [3:0]  PTR_FIRST_FILT  = 4'hC;

    // segment lengths in quanta
    localparam int          LEN_W           = 4;
    localparam int          BIT_LEN_W       = 5;
    localparam logic [3:0]  SYNC_TQ         = 4'h1;
    localparam logic [3:0]  INFO_PROC_TQ    = 4'h2;

    // wake-up line filter time
    localparam int          REF_CLK_MHZ     = 100;
    localparam int          WAKE_FILTER_NS  = 1000;
    localparam int          WAKE_FILTER_CYC = (WAKE_FILTER_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int          WAKE_CNT_W      = 8;

    // bit timing sequencer, one-hot
    typedef enum logic [3:0] {
        SEG_SYNC  = 4'h1,
        SEG_PROP  = 4'h2,
        SEG_PH1   = 4'h4,
        SEG_PH2   = 4'h8
    } cbtfm_seg_type;

endpackage

// *** cbtfm_match_if.sv ***
// carrier between the register top and the acceptance matcher
// assumes both ends sit on the same REF_CLK domain
`timescale 1ns/1ps
interface cbtfm_match_if;
    logic [10:0] sid_mask;    // standard id mask bits
    logic [17:0] eid_mask;    // extended id mask bits
    logic        type_mode;   // frame type must agree when high
    logic [28:0] frame_id;    // received identifier
    logic        frame_ext;   // received frame is extended
    logic [28:0] filter_id;   // filter identifier
    logic        filter_ext;  // filter selects extended frames
    logic        hit;         // combinational match result

    modport requester (output sid_mask, eid_mask, type_mode, frame_id, frame_ext,
                       output filter_id, filter_ext, input hit);
    modport matcher   (input sid_mask, eid_mask, type_mode, frame_id, frame_ext,
                       input filter_id, filter_ext, output hit);
endinterface

// *** cbtfm_matcher.sv ***
// masked identifier compare for one filter against one frame
// assumes inputs are stable for the cycle; the caller registers the result
`timescale 1ns/1ps
module cbtfm_matcher (
    cbtfm_match_if.matcher m
);
    logic [28:0] diff;       // bits that differ
    logic [28:0] care;       // bits that take part
    logic        id_ok;      // identifier agrees
    logic        type_ok;    // frame type agrees

    // compare only the cared-for bits
    always_comb begin
        diff = m.frame_id ^ m.filter_id;
        care[28:18] = m.sid_mask;
        // extended bits masked, only in extended frames
        care[17:0] = m.frame_ext ? m.eid_mask : 18'h00000;
        id_ok = ~|(diff & care);
        type_ok = ~m.type_mode | (m.frame_ext == m.filter_ext);
        m.hit = id_ok & type_ok;
    end
endmodule

// *** cbtfm_top.sv ***
// CAN bit timing configuration, sample point logic and acceptance mask path
// assumes APB from software on REF_CLK; CAN_RX is an asynchronous pin
`timescale 1ns/1ps
module cbtfm_top (
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        CAN_RX,
    input  wire logic        QUANTUM_TICK,
    output logic             SAMPLE_VALID,
    output logic             SAMPLED_BIT,
    output logic             WAKE_DETECT,
    output logic      [3:0]  PROP_TQ,
    output logic      [3:0]  PHASE1_TQ,
    output logic      [3:0]  PHASE2_TQ,
    output logic      [4:0]  BIT_TQ,
    output logic      [4:0]  SAMPLE_POINT_TQ,
    output logic             TRIPLE_SAMPLING,
    input  wire logic        MATCH_REQ,
    input  wire logic [28:0] FRAME_ID,
    input  wire logic        FRAME_EXT,
    input  wire logic [28:0] FILTER_ID,
    input  wire logic        FILTER_EXT,
    input  wire logic [3:0]  FILTER_NUM,
    output logic             MATCH_DONE,
    output logic             MATCH_HIT,
    output logic             MATCH_PTR_VALID,
    output logic      [3:0]  MATCH_BUFFER
);

    logic [15:0]                 timing_reg;    // bit timing configuration
    logic [15:0]                 bufptr_reg;    // filter 12..15 buffer pointers
    logic [15:0]                 mask_sid_reg;  // standard mask and mode
    logic [15:0]                 mask_eid_reg;  // extended mask low half
    logic                        rx_meta;       // first sync stage, read only by rx_sync
    logic                        rx_sync;       // synchronised bus line
    logic [1:0]                  rx_hist;       // line at the two previous quanta
    cbtfm_pkg::cbtfm_seg_type    seg;           // current bit segment
    logic [3:0]                  q_cnt;         // quanta spent in segment
    logic [3:0]                  seg_len;       // length of current segment
    logic [3:0]                  ph1_len;       // phase one quanta
    logic [3:0]                  ph2_len;       // effective phase two quanta
    logic [3:0]                  prop_len;      // propagation quanta
    logic [7:0]                  wake_cnt;      // consecutive dominant cycles
    logic                        access;        // apb access phase awaiting answer
    logic [15:0]                 wr_bits;       // byte-enabled write lanes
    cbtfm_match_if               mif ();

    // segment field plus one, shared by all three length fields
    function automatic logic [3:0] seg_quanta(input logic [2:0] code);
        seg_quanta = {1'b0, code} + 4'h1;
    endfunction

    // byte enables of the low half turned into a bit mask
    function automatic logic [15:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
    endfunction

    assign access  = PSEL & PENABLE & ~PREADY;
    assign wr_bits = lane_mask(PSTRB);

    // segment lengths from the timing register
    always_comb begin
        prop_len = seg_quanta(timing_reg[cbtfm_pkg::PROP_LSB +: cbtfm_pkg::SEG_FIELD_W]);
        ph1_len = seg_quanta(timing_reg[cbtfm_pkg::PH1_LSB +: cbtfm_pkg::SEG_FIELD_W]);
        if (timing_reg[cbtfm_pkg::PH2_SEL_BIT]) begin
            ph2_len = seg_quanta(timing_reg[cbtfm_pkg::PH2_LSB +: cbtfm_pkg::SEG_FIELD_W]);
        end else if (ph1_len > cbtfm_pkg::INFO_PROC_TQ) begin
            ph2_len = ph1_len;
        end else begin
            ph2_len = cbtfm_pkg::INFO_PROC_TQ;
        end
    end

    // length of whichever segment is running
    always_comb begin
        case (seg)
            cbtfm_pkg::SEG_SYNC: seg_len = cbtfm_pkg::SYNC_TQ;
            cbtfm_pkg::SEG_PROP: seg_len = prop_len;
            cbtfm_pkg::SEG_PH1:  seg_len = ph1_len;
            cbtfm_pkg::SEG_PH2:  seg_len = ph2_len;
            default:             seg_len = cbtfm_pkg::SYNC_TQ;
        endcase
    end

    // apb register writes, one cycle after the access phase opens
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            timing_reg   <= cbtfm_pkg::TIMING_RESET;
            bufptr_reg   <= cbtfm_pkg::BUFPTR_RESET;
            mask_sid_reg <= cbtfm_pkg::MASK_SID_RESET;
            mask_eid_reg <= cbtfm_pkg::MASK_EID_RESET;
        end else if (access && PWRITE) begin
            case (PADDR)
                cbtfm_pkg::TIMING_OFFSET: begin
                    timing_reg <= (timing_reg & ~(wr_bits & cbtfm_pkg::TIMING_WMASK))
                                | (PWDATA[15:0] & wr_bits & cbtfm_pkg::TIMING_WMASK);
                end
                cbtfm_pkg::BUFPTR_OFFSET: begin
                    bufptr_reg <= (bufptr_reg & ~(wr_bits & cbtfm_pkg::BUFPTR_WMASK))
                                | (PWDATA[15:0] & wr_bits & cbtfm_pkg::BUFPTR_WMASK);
                end
                cbtfm_pkg::MASK_SID_OFFSET: begin
                    mask_sid_reg <= (mask_sid_reg & ~(wr_bits & cbtfm_pkg::MASK_SID_WMASK))
                                  | (PWDATA[15:0] & wr_bits & cbtfm_pkg::MASK_SID_WMASK);
                end
                cbtfm_pkg::MASK_EID_OFFSET: begin
                    mask_eid_reg <= (mask_eid_reg & ~(wr_bits & cbtfm_pkg::MASK_EID_WMASK))
                                  | (PWDATA[15:0] & wr_bits & cbtfm_pkg::MASK_EID_WMASK);
                end
                default: begin
                    // unmapped or read-only, nothing stored
                end
            endcase
        end
    end

    // apb answer: one wait state, then ready with data and error
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= access;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
            if (access) begin
                // upper and unimplemented bits read zero
                case (PADDR)
                    cbtfm_pkg::TIMING_OFFSET:   PRDATA <= {16'h0000, timing_reg};
                    cbtfm_pkg::BUFPTR_OFFSET:   PRDATA <= {16'h0000, bufptr_reg};
                    cbtfm_pkg::MASK_SID_OFFSET: PRDATA <= {16'h0000, mask_sid_reg};
                    cbtfm_pkg::MASK_EID_OFFSET: PRDATA <= {16'h0000, mask_eid_reg};
                    // live sequencer state for software
                    cbtfm_pkg::STATUS_OFFSET:   PRDATA <= {22'h000000, WAKE_DETECT,
                                                           SAMPLED_BIT, seg, q_cnt};
                    default:                    PSLVERR <= 1'b1;
                endcase
            end
        end
    end

    // two-stage synchroniser on the bus line
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= CAN_RX;
            rx_sync <= rx_meta;
        end
    end

    // quantum sequencer; no resynchronisation, bits run free from reset
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            seg   <= cbtfm_pkg::SEG_SYNC;
            q_cnt <= 4'h0;
        end else if (QUANTUM_TICK) begin
            if (q_cnt == seg_len - 4'h1) begin
                q_cnt <= 4'h0;
                // sync, prop, phase one, phase two
                case (seg)
                    cbtfm_pkg::SEG_SYNC: seg <= cbtfm_pkg::SEG_PROP;
                    cbtfm_pkg::SEG_PROP: seg <= cbtfm_pkg::SEG_PH1;
                    cbtfm_pkg::SEG_PH1:  seg <= cbtfm_pkg::SEG_PH2;
                    cbtfm_pkg::SEG_PH2:  seg <= cbtfm_pkg::SEG_SYNC;
                    default:             seg <= cbtfm_pkg::SEG_SYNC;
                endcase
            end else begin
                q_cnt <= q_cnt + 4'h1;
            end
        end
    end

    // sample point at the last quantum of phase one
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_hist      <= 2'b11;
            SAMPLE_VALID <= 1'b0;
            SAMPLED_BIT  <= 1'b1;
        end else begin
            SAMPLE_VALID <= 1'b0;
            if (QUANTUM_TICK) begin
                rx_hist <= {rx_hist[0], rx_sync};
                // sample at end of phase one
                if (seg == cbtfm_pkg::SEG_PH1 && q_cnt == ph1_len - 4'h1) begin
                    SAMPLE_VALID <= 1'b1;
                    if (timing_reg[cbtfm_pkg::TRIPLE_BIT]) begin
                        SAMPLED_BIT <= (rx_sync & rx_hist[0]) | (rx_sync & rx_hist[1])
                                     | (rx_hist[0] & rx_hist[1]);
                    end else begin
                        SAMPLED_BIT <= rx_sync;
                    end
                end
            end
        end
    end

    // wake-up detect; filtered mode rejects short dominant glitches
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wake_cnt    <= 8'h00;
            WAKE_DETECT <= 1'b0;
        end else if (rx_sync) begin
            wake_cnt    <= 8'h00;
            WAKE_DETECT <= 1'b0;
        end else if (!timing_reg[cbtfm_pkg::WAKE_FILT_BIT]) begin
            WAKE_DETECT <= 1'b1;
        end else if (wake_cnt == 8'(cbtfm_pkg::WAKE_FILTER_CYC - 1)) begin
            WAKE_DETECT <= 1'b1;
        end else begin
            wake_cnt <= wake_cnt + 8'h01;
        end
    end

    // registered timing summary for the bit engine
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PROP_TQ         <= 4'h1;
            PHASE1_TQ       <= 4'h1;
            PHASE2_TQ       <= 4'h2;
            BIT_TQ          <= 5'h05;
            SAMPLE_POINT_TQ <= 5'h03;
            TRIPLE_SAMPLING <= 1'b0;
        end else begin
            PROP_TQ         <= prop_len;
            PHASE1_TQ       <= ph1_len;
            PHASE2_TQ       <= ph2_len;
            BIT_TQ          <= {1'b0, cbtfm_pkg::SYNC_TQ} + {1'b0, prop_len}
                             + {1'b0, ph1_len} + {1'b0, ph2_len};
            SAMPLE_POINT_TQ <= {1'b0, cbtfm_pkg::SYNC_TQ} + {1'b0, prop_len}
                             + {1'b0, ph1_len};
            TRIPLE_SAMPLING <= timing_reg[cbtfm_pkg::TRIPLE_BIT];
        end
    end

    // feed the matcher from the mask registers and the request inputs
    assign mif.sid_mask   = mask_sid_reg[cbtfm_pkg::SID_MASK_LSB +: cbtfm_pkg::SID_W];
    assign mif.eid_mask   = {mask_sid_reg[cbtfm_pkg::EID_HI_W-1:0], mask_eid_reg};
    assign mif.type_mode  = mask_sid_reg[cbtfm_pkg::TYPE_MODE_BIT];
    assign mif.frame_id   = FRAME_ID;
    assign mif.frame_ext  = FRAME_EXT;
    assign mif.filter_id  = FILTER_ID;
    assign mif.filter_ext = FILTER_EXT;

    cbtfm_matcher u_matcher (
        .m (mif.matcher)
    );

    // match result registered with its buffer pointer
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            MATCH_DONE      <= 1'b0;
            MATCH_HIT       <= 1'b0;
            MATCH_PTR_VALID <= 1'b0;
            MATCH_BUFFER    <= 4'h0;
        end else begin
            MATCH_DONE <= MATCH_REQ;
            if (MATCH_REQ) begin
                MATCH_HIT <= mif.hit;
                // pointer for filters 12 to 15
                MATCH_PTR_VALID <= mif.hit && FILTER_NUM >= cbtfm_pkg::PTR_FIRST_FILT;
                MATCH_BUFFER <= bufptr_reg[{FILTER_NUM[1:0], 2'b00} +: cbtfm_pkg::PTR_W];
            end
        end
    end

endmodule

// *** cbtfm_checker.sv ***
// concurrent checks on the top-level ports of the timing and mask block
// assumes binding onto cbtfm_top; one clock, asynchronous active-low reset
`timescale 1ns/1ps
module cbtfm_checker (
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PREADY,
    input wire logic [31:0] PRDATA,
    input wire logic        CAN_RX,
    input wire logic        QUANTUM_TICK,
    input wire logic        SAMPLE_VALID,
    input wire logic        WAKE_DETECT,
    input wire logic [3:0]  PROP_TQ,
    input wire logic [3:0]  PHASE1_TQ,
    input wire logic [3:0]  PHASE2_TQ,
    input wire logic [4:0]  BIT_TQ,
    input wire logic [4:0]  SAMPLE_POINT_TQ,
    input wire logic        MATCH_REQ,
    input wire logic        MATCH_DONE,
    input wire logic        MATCH_HIT,
    input wire logic        MATCH_PTR_VALID
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    a_bit_time_sum: assert property (
        BIT_TQ == PROP_TQ + PHASE1_TQ + PHASE2_TQ + 5'h01) else $error("bit time off");
    a_sample_point: assert property (
        SAMPLE_POINT_TQ == PROP_TQ + PHASE1_TQ + 5'h01) else $error("sample point off");
    a_seg_lengths: assert property (
        PROP_TQ inside {[4'h1:4'h8]} && PHASE1_TQ inside {[4'h1:4'h8]}
        && PHASE2_TQ inside {[4'h1:4'h8]}) else $error("segment out of range");
    a_apb_wait: assert property (
        PSEL && PENABLE && !PREADY |=> PREADY) else $error("no bus answer");
    a_rdata_upper: assert property (
        PREADY |-> PRDATA[31:16] == 16'h0000 ##1 !PREADY) else $error("bad upper data");
    a_match_done: assert property (
        MATCH_REQ |=> MATCH_DONE) else $error("match not answered");
    a_ptr_needs_hit: assert property (
        MATCH_PTR_VALID |-> MATCH_HIT) else $error("pointer without hit");
    a_hit_hold: assert property (
        !MATCH_DONE |-> $stable(MATCH_HIT) && $stable(MATCH_PTR_VALID))
        else $error("result moved");
    a_sample_tick: assert property (
        SAMPLE_VALID |-> $past(QUANTUM_TICK) && !$past(SAMPLE_VALID)) else $error("stray sample");
    a_wake_cause: assert property (
        $rose(WAKE_DETECT) |-> !$past(CAN_RX, 3)) else $error("wake without dominant line");
endmodule

// *** cbtfm_node.sv ***
// far-side bus node: idles recessive, drives a dominant stretch on demand
// assumes go is a one-cycle pulse on the block's clock
`timescale 1ns/1ps
module cbtfm_node (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       go,
    input  wire logic [7:0] len,
    output logic            rx
);
    logic [7:0] left; // dominant cycles still to send
    // reload on demand, else count the stretch down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left <= 8'h00;
        end else if (go) begin
            left <= len;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    // released line returns recessive through the bus termination
    assign rx = (left == 8'h00);
endmodule

// *** tb.sv ***
// self-checking bench for the bit timing and acceptance mask block
// assumes package, matcher, top, node model and checker compiled first
`timescale 1ns/1ps
module tb;
    logic        REF_CLK, RST_N, PSEL, PENABLE, PWRITE, QUANTUM_TICK, CAN_RX;
    logic        MATCH_REQ, FRAME_EXT, FILTER_EXT, PREADY, PSLVERR, SAMPLE_VALID;
    logic        SAMPLED_BIT, WAKE_DETECT, TRIPLE_SAMPLING, MATCH_DONE, MATCH_HIT;
    logic        MATCH_PTR_VALID, go, fx, fe, h;
    logic [3:0]  PSTRB, PROP_TQ, PHASE1_TQ, PHASE2_TQ, FILTER_NUM, MATCH_BUFFER, n;
    logic [4:0]  BIT_TQ, SAMPLE_POINT_TQ;
    logic [7:0]  len;
    logic [11:0] PADDR;
    logic [15:0] t, sm, em, bp;
    logic [15:0] ones [4] = '{16'h47FF, 16'hFFFF, 16'hFFEB, 16'hFFFF}; // all-ones readback
    logic [28:0] FRAME_ID, FILTER_ID, fi, id, care;
    logic [31:0] PWDATA, PRDATA;
    logic [33:0] aq[$];     // bus results still due
    logic [5:0]  mq[$];     // match results still due
    int          miscompares, checks, i, r;
    int          seed = 51; // fixed seed, repeatable run
    cbtfm_top i_dut (.REF_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
        .PRDATA, .PREADY, .PSLVERR, .CAN_RX, .QUANTUM_TICK, .SAMPLE_VALID, .SAMPLED_BIT,
        .WAKE_DETECT, .PROP_TQ, .PHASE1_TQ, .PHASE2_TQ, .BIT_TQ, .SAMPLE_POINT_TQ,
        .TRIPLE_SAMPLING, .MATCH_REQ, .FRAME_ID, .FRAME_EXT, .FILTER_ID, .FILTER_EXT,
        .FILTER_NUM, .MATCH_DONE, .MATCH_HIT, .MATCH_PTR_VALID, .MATCH_BUFFER);
    cbtfm_node i_node (.clk(REF_CLK), .rst_n(RST_N), .go, .len, .rx(CAN_RX));
    // 100 MHz clock
    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end
    // one quantum every second cycle
    always @(posedge REF_CLK) QUANTUM_TICK <= ~QUANTUM_TICK;
    task automatic fail(input string m);
        miscompares++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic close_out;
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_apb(input logic [33:0] e);
        checks++;
        if (PSLVERR !== e[32] || (e[33] && PRDATA !== e[31:0])) fail("bus answer");
    endtask
    task automatic cmp_match(input logic [5:0] e);
        checks++;
        if ({MATCH_HIT, MATCH_PTR_VALID} !== e[5:4] || (e[4] && MATCH_BUFFER !== e[3:0]))
            fail("match result");
    endtask
    task automatic cmp_lvl(input logic g, input logic e);
        checks++;
        if (g !== e) fail("line level");
    endtask
    // one transfer; request held until ready, then an idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [33:0] e);
        int k;
        k = 0;
        aq.push_back(e);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge REF_CLK);
            k++;
        end while (PREADY !== 1'b1 && k < 40);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (k == 40) begin
            fail("bus timeout");
            close_out();
        end
        @(posedge REF_CLK);
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0000, d}, 34'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] d);
        apb(1'b0, a, 32'h0, {2'b10, 16'h0000, d});
    endtask
    // segment lengths as the timing word demands
    task automatic tq(input logic [15:0] v);
        logic [3:0] p, a, b;
        p = {1'b0, v[2:0]} + 4'h1;
        a = {1'b0, v[5:3]} + 4'h1;
        b = v[7] ? {1'b0, v[10:8]} + 4'h1 : (a > 4'h2 ? a : cbtfm_pkg::INFO_PROC_TQ);
        checks++;
        if ({PROP_TQ, PHASE1_TQ, PHASE2_TQ, TRIPLE_SAMPLING} !== {p, a, b, v[6]}
            || BIT_TQ !== {1'b0, p} + a + b + 5'h01 || SAMPLE_POINT_TQ !== {1'b0, p} + a + 5'h01)
            fail("timing fields");
    endtask
    // dominant stretch from the node, wake level checked after w cycles
    task automatic pulse(input logic [7:0] c, input int w, input logic e);
        go <= 1'b1;
        len <= c;
        @(posedge REF_CLK);
        go <= 1'b0;
        repeat (w) @(posedge REF_CLK);
        cmp_lvl(WAKE_DETECT, e);
    endtask
    // retire the oldest note whenever a result shows
    always @(posedge REF_CLK) begin
        if ((PSEL & PENABLE & PREADY) === 1'b1 && aq.size() > 0) cmp_apb(aq.pop_front());
        if (MATCH_DONE === 1'b1 && mq.size() > 0) cmp_match(mq.pop_front());
    end
    initial begin
        {RST_N, PSEL, PENABLE, PWRITE, MATCH_REQ, FRAME_EXT, FILTER_EXT, go} = 8'h00;
        {PADDR, PWDATA, FRAME_ID, FILTER_ID, FILTER_NUM, len} = '0;
        {QUANTUM_TICK, miscompares, checks, PSTRB} = {1'b0, 64'h0, 4'hF};
        repeat (3) @(posedge REF_CLK);
        RST_N <= 1'b1;
        for (i = 0; i < 4; i++) begin
            rd(12'(4 * i), 16'h0000);
            wr(12'(4 * i), 16'hFFFF);
            rd(12'(4 * i), ones[i]);
        end
        apb(1'b0, 12'h014, 32'h0, {2'b11, 32'h0});
        apb(1'b1, 12'h018, 32'hFFFF, {2'b01, 32'h0});
        // status word is read-only: a write is dropped without error
        apb(1'b1, 12'h010, 32'hFFFF, 34'h0);
        apb(1'b0, 12'h010, 32'h0, 34'h0);
        for (i = 0; i < 12; i++) begin
            t = 16'($random(seed));
            t[7] = i[0];
            wr(12'h000, t);
            tq(t & 16'h47FF);
        end
        for (r = 0; r < 4; r++) begin
            {sm, em, bp} = {16'($random(seed)) & 16'hFFEB, 32'($random(seed))};
            wr(12'h008, sm);
            wr(12'h00C, em);
            wr(12'h004, bp);
            for (i = 0; i < 16; i++) begin
                {fi, fx, n} = 34'($random(seed));
                fe = (i % 4 == 3) ? ~fx : fx;
                id = fi ^ (i[0] ? 29'($random(seed) & $random(seed) & $random(seed)) : 29'h0);
                care = {sm[15:5], fx ? {sm[1:0], em} : 18'h0};
                h = ((id ^ fi) & care) == 29'h0 && (!sm[3] || fx == fe);
                mq.push_back({h, h && n >= 4'hC, bp[4 * n[1:0] +: 4]});
                {MATCH_REQ, FRAME_ID, FRAME_EXT} <= {1'b1, id, fx};
                {FILTER_ID, FILTER_EXT, FILTER_NUM} <= {fi, fe, n};
                @(posedge REF_CLK);
            end
            MATCH_REQ <= 1'b0;
        end
        wr(12'h000, 16'h0000);
        pulse(8'd5, 4, 1'b1);
        pulse(8'd0, 10, 1'b0);
        wr(12'h000, 16'h4040);
        pulse(8'd50, 45, 1'b0);
        pulse(8'd120, 110, 1'b1);
        cmp_lvl(SAMPLED_BIT, 1'b0);
        RST_N <= 1'b0;
        // two edges in reset, so past values up to two cycles back seen after release are reset values
        repeat (2) @(posedge REF_CLK);
        RST_N <= 1'b1;
        rd(12'h000, 16'h0000);
        tq(16'h0000);
        repeat (5) @(posedge REF_CLK);
        close_out();
    end
endmodule
bind cbtfm_top cbtfm_checker i_chk (.REF_CLK, .RST_N, .PSEL, .PENABLE, .PREADY, .PRDATA,
    .CAN_RX, .QUANTUM_TICK, .SAMPLE_VALID, .WAKE_DETECT, .PROP_TQ, .PHASE1_TQ, .PHASE2_TQ,
    .BIT_TQ, .SAMPLE_POINT_TQ, .MATCH_REQ, .MATCH_DONE, .MATCH_HIT, .MATCH_PTR_VALID);
